// ===== src/tws_pkg.sv
package tws_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_SMODE = 8'h08;
  localparam logic [7:0] OFF_CWAVE = 8'h10;
  localparam logic [7:0] OFF_STAT  = 8'h20;
  localparam logic [7:0] OFF_RHR   = 8'h30;
  localparam logic [7:0] OFF_THR   = 8'h34;
  // control_reg command bits
  localparam int CTL_MDIS  = 2;
  localparam int CTL_SEN   = 4;
  localparam int CTL_SDIS  = 5;
  localparam int CTL_SWRST = 7;
  // slave_mode_reg own address field
  localparam int OWN_SLAVE_ADDRESS_LSB = 16;
  localparam int OWN_SLAVE_ADDRESS_MSB = 22;
  // status word bit positions
  localparam int BIT_TRANSMISSION_COMPLETE_FLAG = 0;
  localparam int BIT_RECEIVE_READY_FLAG  = 1;
  localparam int BIT_TRANSMIT_READY_FLAG  = 2;
  localparam int BIT_SLAVE_DIRECTION_FLAG = 3;
  localparam int BIT_SLAVE_ACCESS_FLAG  = 4;
  localparam int BIT_GENERAL_CALL_ACCESS_FLAG   = 5;
  localparam int BIT_NACK   = 8;
  localparam int BIT_CLOCK_WAIT_STATE_FLAG  = 10;
  localparam int BIT_END_OF_ACCESS_FLAG = 11;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [6:0] OWN_SLAVE_ADDRESS_RST   = 7'h00;
  localparam logic [2:0] BIT_LAST   = 3'h7;

  typedef struct packed {
    logic endAccess;
    logic nack;
    logic genCall;
    logic svAccess;
    logic slave_direction_flag;
    logic txReady;
    logic rxReady;
    logic txComplete;
  } tws_status_t;

  localparam tws_status_t STATUS_RST = '{txComplete: 1'b1, default: 1'b0};

  typedef enum logic [3:0] {
    LK_IDLE, LK_ADDR, LK_AACK, LK_ACKS, LK_RX, LK_RACK,
    LK_HOLDRX, LK_TX, LK_TACK, LK_TLOAD, LK_HOLDTX
  } tws_state_t;
endpackage

// ===== src/tws_slave.sv
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
// Behaviour
// RULE1: slave never makes start, repeated start or stop; sda moves only while scl low.
// RULE2: software loads own address, disables master mode, then enables slave mode.
// RULE3: clock waveform settings are accepted but ignored; scl comes from master.
// RULE4: on matching address after start, set slave access and direction flags.
// RULE5: access stays until stop or repeated start, which raises end-of-access.
// RULE6: master read streams holding bytes until stop or foreign restart, then complete.
// RULE7: transmit ready drops on holding write, rises after byte is acked or nacked.
// RULE8: a transmitted byte not acknowledged sets the not-acknowledge flag.
// RULE9: software clears transmit ready by slave disable followed by slave enable.
// RULE10: receive ready set when byte lands in holding register, cleared by reading it.
// RULE11: master write accepts bytes until stop or foreign restart, then complete.
// RULE12: general call address raises the general call flag.
// RULE13: software decodes general call commands and may load a new own address.
// RULE14: read mode with empty shifter holds scl low after ack until loaded.
// RULE15: write mode with both full holds scl low before ack until register read.
// RULE16: clock wait flag follows scl holding exactly.
// RULE17: re-addressing restart with direction reversal does not raise completion.
// RULE18: after write-to-read reversal with nothing loaded, scl is stretched.
// RULE19: direction flag reads zero whenever slave access is low.
// RULE20: master always follows a nack with stop or repeated start.
// RULE21: dma transmit: set pointers, enable, await end, disable; completion if gating.
// RULE22: dma receive: set pointers, enable, await end, disable; completion if gating.
// RULE23: own address writes only take effect before slave enable or after general call.
// RULE24: matching address is acked by pulling sda low; others left released.
// RULE25: each received data byte is acked unless slave mode is disabled.
module tws_slave (
  input  wire logic        ref_clk,  // 125 MHz clock
  input  wire logic        rst_n,    // synchronous reset, active low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb direction
  input  wire logic [7:0]  paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb unmapped address
  input  wire logic        sclIn,    // scl pin level
  output logic             sclOut,   // scl drive value, always low
  output logic             sclOe,    // scl pulled low while high
  input  wire logic        sdaIn,    // sda pin level
  output logic             sdaOut,   // sda drive value, always low
  output logic             sdaOe,    // sda pulled low while high
  output logic             dmaTxReq, // dma may write transmit holding reg
  output logic             dmaRxReq  // dma may read receive holding reg
);
  tws_pkg::tws_status_t st;
  tws_pkg::tws_state_t  state;
  logic       sclM, sclS, sclD, sdaM, sdaS, sdaD;
  logic       sclRise, sclFall, startEv, stopEv;
  logic [2:0] cnt;
  logic [7:0] sh, rhr, thr, byteIn;
  logic [6:0] ownAddr;
  logic       slaveEn, thrFull, rstAll, gcall, hit, addrDone;
  logic       acc, wrAcc, rdAcc, mapped, ctlWr, statRd, loadSlot;
  logic       txLoad, rhrLoad, nackEv, ackEv;
  logic [31:0] rdWord;

  // two flops per pin before use; the third only delays for edge finding
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {sclM, sclS, sclD} <= 3'h7;
      {sdaM, sdaS, sdaD} <= 3'h7;
    end else begin
      {sclM, sclS, sclD} <= {sclIn, sclM, sclS};
      {sdaM, sdaS, sdaD} <= {sdaIn, sdaM, sdaS};
    end
  end

  assign sclRise = sclS & ~sclD;
  assign sclFall = ~sclS & sclD;
  assign startEv = sclS & sclD & sdaD & ~sdaS;
  assign stopEv  = sclS & sclD & ~sdaD & sdaS;

  assign acc    = psel & penable;
  assign wrAcc  = acc & pwrite;
  assign rdAcc  = acc & ~pwrite;
  assign ctlWr  = wrAcc && paddr == tws_pkg::OFF_CTRL;
  assign statRd = rdAcc && paddr == tws_pkg::OFF_STAT;
  assign rstAll = ~rst_n | (ctlWr & pwdata[tws_pkg::CTL_SWRST]);
  assign mapped = paddr inside {tws_pkg::OFF_CTRL, tws_pkg::OFF_SMODE, tws_pkg::OFF_CWAVE,
                                tws_pkg::OFF_STAT, tws_pkg::OFF_RHR, tws_pkg::OFF_THR};
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  always_comb begin
    rdWord = '0;
    case (paddr)
      tws_pkg::OFF_STAT: begin
        rdWord[tws_pkg::BIT_TRANSMISSION_COMPLETE_FLAG] = st.txComplete;
        rdWord[tws_pkg::BIT_RECEIVE_READY_FLAG]  = st.rxReady;
        rdWord[tws_pkg::BIT_TRANSMIT_READY_FLAG]  = st.txReady;
        rdWord[tws_pkg::BIT_SLAVE_DIRECTION_FLAG] = st.slave_direction_flag & st.svAccess; // see RULE19
        rdWord[tws_pkg::BIT_SLAVE_ACCESS_FLAG]  = st.svAccess;
        rdWord[tws_pkg::BIT_GENERAL_CALL_ACCESS_FLAG]   = st.genCall;
        rdWord[tws_pkg::BIT_NACK]   = st.nack;
        rdWord[tws_pkg::BIT_CLOCK_WAIT_STATE_FLAG]  = sclOe; // see RULE16
        rdWord[tws_pkg::BIT_END_OF_ACCESS_FLAG] = st.endAccess;
      end
      tws_pkg::OFF_SMODE: rdWord[tws_pkg::OWN_SLAVE_ADDRESS_MSB:tws_pkg::OWN_SLAVE_ADDRESS_LSB] = ownAddr;
      tws_pkg::OFF_RHR:   rdWord[7:0] = rhr;
      default:            rdWord = '0; // see RULE3
    endcase
  end

  // read data is caught in the setup phase so it comes from a flop
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      prdata <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rdWord;
    end
  end

  // slave enable and own address; clock waveform writes are dropped on purpose
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      slaveEn <= 1'b0;
      ownAddr <= tws_pkg::OWN_SLAVE_ADDRESS_RST;
    end else begin
      if (ctlWr & pwdata[tws_pkg::CTL_SDIS]) begin
        slaveEn <= 1'b0;
      end else if (ctlWr & pwdata[tws_pkg::CTL_SEN]) begin
        slaveEn <= 1'b1;
      end
      if (wrAcc && paddr == tws_pkg::OFF_SMODE && (!slaveEn || st.genCall)) begin // see RULE23
        ownAddr <= pwdata[tws_pkg::OWN_SLAVE_ADDRESS_MSB:tws_pkg::OWN_SLAVE_ADDRESS_LSB];
      end
    end
  end

  assign byteIn   = {sh[6:0], sdaS};
  assign gcall    = byteIn[7:1] == tws_pkg::GCALL_ADDR && !byteIn[0];
  assign hit      = slaveEn && (byteIn[7:1] == ownAddr || gcall);
  assign addrDone = state == tws_pkg::LK_ADDR && sclRise && cnt == tws_pkg::BIT_LAST;
  assign loadSlot = sclFall && (state == tws_pkg::LK_TLOAD ||
                                (state == tws_pkg::LK_ACKS && st.slave_direction_flag));
  assign txLoad   = thrFull && !startEv && !stopEv &&
                    (loadSlot || state == tws_pkg::LK_HOLDTX);
  assign rhrLoad  = !st.rxReady && !startEv && !stopEv &&
                    ((state == tws_pkg::LK_RACK && sclFall) || state == tws_pkg::LK_HOLDRX);
  assign nackEv   = state == tws_pkg::LK_TACK && sclRise && sdaS;
  assign ackEv    = state == tws_pkg::LK_TACK && sclRise && !sdaS;

  // transmit holding register
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      thr     <= '0;
      thrFull <= 1'b0;
    end else if (ctlWr & pwdata[tws_pkg::CTL_SDIS]) begin
      thrFull <= 1'b0;
    end else if (wrAcc && paddr == tws_pkg::OFF_THR) begin
      thr     <= pwdata[7:0];
      thrFull <= 1'b1;
    end else if (txLoad) begin
      thrFull <= 1'b0;
    end
  end

  // status flags: a hardware set always beats a software clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      st <= tws_pkg::STATUS_RST;
    end else begin
      if (addrDone && hit) begin
        st.svAccess   <= 1'b1; // see RULE4
        st.slave_direction_flag     <= byteIn[0];
        st.txComplete <= 1'b0; // see RULE17
      end else if (st.svAccess && (stopEv || addrDone)) begin
        st.svAccess   <= 1'b0; // see RULE6, RULE11
        st.txComplete <= 1'b1;
      end
      if (st.svAccess && (startEv || stopEv)) begin
        st.endAccess <= 1'b1; // see RULE5
      end else if (statRd && prdata[tws_pkg::BIT_END_OF_ACCESS_FLAG]) begin
        st.endAccess <= 1'b0;
      end
      if (addrDone && hit && gcall) begin
        st.genCall <= 1'b1; // see RULE12
      end else if (statRd && prdata[tws_pkg::BIT_GENERAL_CALL_ACCESS_FLAG]) begin
        st.genCall <= 1'b0;
      end
      if (nackEv) begin
        st.nack <= 1'b1; // see RULE8
      end else if (statRd && prdata[tws_pkg::BIT_NACK]) begin
        st.nack <= 1'b0;
      end
      if (((nackEv || ackEv) && !thrFull) || (addrDone && hit && byteIn[0] && !thrFull)) begin
        st.txReady <= 1'b1; // see RULE7
      end else if ((wrAcc && paddr == tws_pkg::OFF_THR) ||
                   (ctlWr & pwdata[tws_pkg::CTL_SDIS])) begin
        st.txReady <= 1'b0; // see RULE7, RULE9
      end
      if (rhrLoad) begin
        st.rxReady <= 1'b1; // see RULE10
      end else if (rdAcc && paddr == tws_pkg::OFF_RHR) begin
        st.rxReady <= 1'b0;
      end
    end
  end

  // bit engine; sda only changes after an scl fall or while scl is stretched low, never makes start/stop
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      state <= tws_pkg::LK_IDLE;
      cnt   <= '0;
      sh    <= '0;
      rhr   <= '0;
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
    end else if (stopEv || startEv) begin
      state <= stopEv ? tws_pkg::LK_IDLE : tws_pkg::LK_ADDR;
      cnt   <= '0;
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
    end else begin
      if (sclOe && (state == tws_pkg::LK_ACKS || state == tws_pkg::LK_TX)) begin
        sclOe <= 1'b0; // see RULE1, RULE16
      end
      case (state)
        tws_pkg::LK_ADDR, tws_pkg::LK_RX: if (sclRise) begin
          sh  <= byteIn;
          cnt <= cnt + 3'h1;
          if (cnt == tws_pkg::BIT_LAST) begin
            if (state == tws_pkg::LK_RX) begin
              state <= tws_pkg::LK_RACK;
            end else begin
              state <= hit ? tws_pkg::LK_AACK : tws_pkg::LK_IDLE; // see RULE24
            end
          end
        end
        tws_pkg::LK_AACK: if (sclFall) begin
          sdaOe <= 1'b1; // see RULE24, RULE1
          state <= tws_pkg::LK_ACKS;
        end
        tws_pkg::LK_RACK: if (sclFall) begin
          if (st.rxReady) begin
            sclOe <= 1'b1; // see RULE15
            state <= tws_pkg::LK_HOLDRX;
          end else begin
            rhr   <= sh;
            sdaOe <= slaveEn; // see RULE25
            state <= tws_pkg::LK_ACKS;
          end
        end
        tws_pkg::LK_HOLDRX: if (!st.rxReady) begin
          rhr   <= sh;
          sdaOe <= slaveEn; // see RULE25
          state <= tws_pkg::LK_ACKS;
        end
        tws_pkg::LK_ACKS, tws_pkg::LK_TLOAD: if (sclFall) begin
          cnt <= '0;
          if (state == tws_pkg::LK_ACKS && !st.slave_direction_flag) begin
            sdaOe <= 1'b0;
            state <= tws_pkg::LK_RX;
          end else if (thrFull) begin
            sh    <= thr;
            sdaOe <= !thr[7];
            state <= tws_pkg::LK_TX;
          end else begin
            sdaOe <= 1'b0;
            sclOe <= 1'b1; // see RULE14, RULE18
            state <= tws_pkg::LK_HOLDTX;
          end
        end
        tws_pkg::LK_HOLDTX: if (thrFull) begin
          sh    <= thr;
          sdaOe <= !thr[7];
          cnt   <= '0;
          state <= tws_pkg::LK_TX;
        end
        tws_pkg::LK_TX: if (sclFall) begin
          if (cnt == tws_pkg::BIT_LAST) begin
            sdaOe <= 1'b0;
            state <= tws_pkg::LK_TACK;
          end else begin
            sh    <= {sh[6:0], 1'b0};
            sdaOe <= !sh[6]; // see RULE6
            cnt   <= cnt + 3'h1;
          end
        end
        // after a nack the master must end the frame, so just wait
        tws_pkg::LK_TACK: if (sclRise) begin
          state <= sdaS ? tws_pkg::LK_IDLE : tws_pkg::LK_TLOAD; // see RULE20
        end
        tws_pkg::LK_IDLE: state <= tws_pkg::LK_IDLE;
        default: state <= tws_pkg::LK_IDLE;
      endcase
    end
  end

  assign sclOut   = 1'b0;
  assign sdaOut   = 1'b0;
  assign dmaTxReq = st.txReady;
  assign dmaRxReq = st.rxReady;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rstAll);

  sequence sAddrHit;
    addrDone && hit;
  endsequence
  sequence sEndFrame;
    st.svAccess && stopEv;
  endsequence

  a_sda_low_only: assert property ($rose(sdaOe) |-> !sclS) // see RULE1
    else $error("sda drive began while scl high");
  a_sda_before_scl: assert property ($fell(sclOe) |-> $stable(sdaOe)) // see RULE1
    else $error("sda moved as scl was let go");
  a_addr_flags: assert property (sAddrHit |=> st.svAccess
                                 && st.slave_direction_flag == $past(byteIn[0])) // see RULE4
    else $error("address match did not set access flags");
  a_end_access: assert property (st.svAccess && (startEv || stopEv) |=> st.endAccess) // see RULE5
    else $error("end of access not flagged");
  a_stop_done: assert property (sEndFrame |=> st.txComplete && !st.svAccess) // see RULE11
    else $error("stop did not complete access");
  a_readdr_keep: assert property (sAddrHit |=> !st.txComplete) // see RULE17
    else $error("completion set on re-address");
  a_thr_drop: assert property (wrAcc && paddr == tws_pkg::OFF_THR && !(nackEv || ackEv)
                               && !addrDone |=> !st.txReady) // see RULE7
    else $error("transmit ready stayed after write");
  a_nack_flag: assert property (nackEv |=> st.nack ##1 state == tws_pkg::LK_IDLE
                                || st.nack) // see RULE8
    else $error("nack not flagged");
  a_rx_load: assert property (rhrLoad |=> st.rxReady && rhr == $past(sh)) // see RULE10
    else $error("receive byte not loaded");
  a_tx_stretch: assert property (state == tws_pkg::LK_HOLDTX && !thrFull |-> sclOe) // see RULE14
    else $error("read stretch released early");
  a_rx_stretch: assert property (state == tws_pkg::LK_HOLDRX |-> sclOe && !sdaOe) // see RULE15
    else $error("write stretch not held");
  a_gcall_flag: assert property (sAddrHit ##0 gcall |=> st.genCall) // see RULE12
    else $error("general call not flagged");
  a_own_slave_address_lock: assert property (slaveEn && !st.genCall |=> $stable(ownAddr)) // see RULE23
    else $error("own address changed while locked");
endmodule // tws_slave

// ===== dv/tws_master_model.sv
`timescale 1ns/10ps
module tws_master_model (
  input  wire logic scl,    // scl wire level
  input  wire logic sda,    // sda wire level
  output logic      sclLow, // master pulls scl low
  output logic      sdaLow, // master pulls sda low
  output logic      hung    // slave held scl past the limit
);
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    hung   = 1'b0;
  end
  // release scl, then wait while the slave stretches it
  task automatic rise();
    int n;
    sclLow = 1'b0;
    #1;
    n = 0;
    while (scl !== 1'b1 && n < 3000) begin
      #8;
      n++;
    end
    if (n == 3000) hung = 1'b1;
    #19;
  endtask
  // start and repeated start come only from this side
  task automatic start();
    sdaLow = 1'b0;
    #20;
    rise();
    sdaLow = 1'b1;
    #20;
    sclLow = 1'b1;
    #20;
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    #20;
    rise();
    #20;
    sdaLow = 1'b0;
    #40;
  endtask
  task automatic bitx(input logic o, output logic i);
    sdaLow = !o;
    #20;
    rise();
    i = sda;
    #20;
    sclLow = 1'b1;
    #20;
  endtask
  // msb first, eight bits then the ninth ack bit
  task automatic xfer(input logic [7:0] o, input logic ackOut,
                      output logic [7:0] i, output logic ackIn);
    logic a;
    for (int k = 7; k >= 0; k--) begin
      bitx(o[k], i[k]);
    end
    bitx(!ackOut, a);
    ackIn = !a;
  endtask
endmodule // tws_master_model

// ===== dv/tws_slave_test.sv
`timescale 1ns/10ps
module tws_slave_test;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, b0, b1;
  logic [31:0] pwdata, prdata, rd;
  logic        sclOut, sclOe, sdaOut, sdaOe, dmaTxReq, dmaRxReq;
  logic        sclLow, sdaLow, hung, a0, a1;
  wire         scl, sda;
  int          fails, samples_checked, cyc;
  // open-drain wires with pull-ups
  assign scl = !(sclOe | sclLow);
  assign sda = !(sdaOe | sdaLow);
  tws_slave i_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sclIn(scl), .sclOut, .sclOe, .sdaIn(sda),
    .sdaOut, .sdaOe, .dmaTxReq, .dmaRxReq);
  tws_master_model i_master (.scl, .sda, .sclLow, .sdaLow, .hung);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // data only changes while scl is low
  always @(sdaOe) if (rst_n === 1'b1) check({31'h0, scl}, 32'h0);
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  function automatic logic [31:0] bt(input int p);
    return 32'h1 << p;
  endfunction
  // wait up to 3000 clocks for the slave to start holding scl, then check that it is held
  task automatic wait_hold();
    int n;
    n = 0;
    while (sclOe !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, sclOe}, 32'h1);
  endtask
  task automatic t_regs();
    rdc(tws_pkg::OFF_STAT, 32'hFFFFFFFF, bt(tws_pkg::BIT_TRANSMISSION_COMPLETE_FLAG));
    apb(1'b1, tws_pkg::OFF_CWAVE, 32'h0000FFFF);
    rdc(tws_pkg::OFF_CWAVE, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, tws_pkg::OFF_SMODE, {9'h0, 7'h3A, 16'h0});
    apb(1'b1, tws_pkg::OFF_CTRL, bt(tws_pkg::CTL_MDIS) | bt(tws_pkg::CTL_SEN));
    $display("test regs done");
  endtask
  task automatic t_write();
    i_master.start();
    i_master.xfer(8'h74, 1'b0, b0, a0);
    check({31'h0, a0}, 32'h1);
    rdc(tws_pkg::OFF_STAT, bt(4) | bt(3), bt(tws_pkg::BIT_SLAVE_ACCESS_FLAG));
    i_master.xfer(8'hC3, 1'b0, b0, a0);
    check({31'h0, a0 & dmaRxReq}, 32'h1);
    fork
      i_master.xfer(8'h5A, 1'b0, b0, a1);
      begin
        wait_hold();
        rdc(tws_pkg::OFF_STAT, bt(tws_pkg::BIT_CLOCK_WAIT_STATE_FLAG), bt(tws_pkg::BIT_CLOCK_WAIT_STATE_FLAG));
        rdc(tws_pkg::OFF_RHR, 32'hFF, 32'hC3);
      end
    join
    check({31'h0, a1}, 32'h1);
    check({31'h0, dmaRxReq}, 32'h1);
    rdc(tws_pkg::OFF_STAT, bt(tws_pkg::BIT_CLOCK_WAIT_STATE_FLAG), 32'h0);
    rdc(tws_pkg::OFF_RHR, 32'hFF, 32'h5A);
    rdc(tws_pkg::OFF_STAT, bt(tws_pkg::BIT_RECEIVE_READY_FLAG), 32'h0);
    check({31'h0, dmaRxReq}, 32'h0);
    i_master.stop();
    rdc(tws_pkg::OFF_STAT, 32'h0000081D, 32'h00000801);
    $display("test write done");
  endtask
  task automatic t_read();
    apb(1'b1, tws_pkg::OFF_THR, 32'hA5);
    rdc(tws_pkg::OFF_STAT, bt(tws_pkg::BIT_TRANSMIT_READY_FLAG), 32'h0);
    i_master.start();
    i_master.xfer(8'h75, 1'b0, b0, a0);
    check({31'h0, a0}, 32'h1);
    rdc(tws_pkg::OFF_STAT, bt(4) | bt(3), bt(4) | bt(3));
    fork
      begin
        i_master.xfer(8'hFF, 1'b1, b0, a0);
        i_master.xfer(8'hFF, 1'b0, b1, a1);
      end
      begin
        wait_hold();
        rdc(tws_pkg::OFF_STAT, bt(10) | bt(2), bt(10) | bt(2));
        check({31'h0, dmaTxReq}, 32'h1);
        apb(1'b1, tws_pkg::OFF_THR, 32'h3C);
        rdc(tws_pkg::OFF_STAT, bt(tws_pkg::BIT_TRANSMIT_READY_FLAG), 32'h0);
      end
    join
    check({b0, b1}, 32'hA53C);
    rdc(tws_pkg::OFF_STAT, bt(tws_pkg::BIT_NACK), bt(tws_pkg::BIT_NACK));
    i_master.stop();
    rdc(tws_pkg::OFF_STAT, 32'h19, 32'h1);
    $display("test read done");
  endtask
  task automatic t_reverse();
    i_master.start();
    i_master.xfer(8'h74, 1'b0, b0, a0);
    i_master.xfer(8'h55, 1'b0, b0, a0);
    rdc(tws_pkg::OFF_RHR, 32'hFF, 32'h55);
    i_master.start();
    i_master.xfer(8'h75, 1'b0, b0, a0);
    rdc(tws_pkg::OFF_STAT, 32'h19, 32'h18);
    fork
      i_master.xfer(8'hFF, 1'b0, b0, a0);
      begin
        wait_hold();
        apb(1'b1, tws_pkg::OFF_THR, 32'h0F);
      end
    join
    check({24'h0, b0}, 32'h0F);
    i_master.stop();
    rdc(tws_pkg::OFF_STAT, 32'h19, 32'h1);
    $display("test reverse done");
  endtask
  task automatic t_gcall();
    apb(1'b1, tws_pkg::OFF_SMODE, {9'h0, 7'h11, 16'h0});
    i_master.start();
    i_master.xfer(8'h22, 1'b0, b0, a0);
    check({31'h0, a0}, 32'h0);
    i_master.stop();
    i_master.start();
    i_master.xfer(8'h00, 1'b0, b0, a0);
    apb(1'b1, tws_pkg::OFF_SMODE, {9'h0, 7'h11, 16'h0});
    rdc(tws_pkg::OFF_STAT, bt(tws_pkg::BIT_GENERAL_CALL_ACCESS_FLAG), bt(tws_pkg::BIT_GENERAL_CALL_ACCESS_FLAG));
    i_master.stop();
    i_master.start();
    i_master.xfer(8'h22, 1'b0, b0, a0);
    check({31'h0, a0}, 32'h1);
    i_master.stop();
    apb(1'b1, tws_pkg::OFF_CTRL, bt(tws_pkg::CTL_SDIS));
    apb(1'b1, tws_pkg::OFF_CTRL, bt(tws_pkg::CTL_SEN));
    rdc(tws_pkg::OFF_STAT, bt(tws_pkg::BIT_TRANSMIT_READY_FLAG), 32'h0);
    $display("test gcall done");
  endtask
  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    fails   = 0;
    samples_checked = 0;
    cyc     = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_write();
    t_read();
    t_reverse();
    t_gcall();
    check({31'h0, hung}, 32'h0);
    test_done();
  end
endmodule // tws_slave_test
